// >>> pkg/tcpwm_regs.vh
// Register offsets, field positions and reset values of the timer/counter
`ifndef TCPWM_REGS_VH
`define TCPWM_REGS_VH

`define TCPWM_OFF_CTRL     12'h000
`define TCPWM_OFF_PRESC    12'h004
`define TCPWM_OFF_TOP      12'h008
`define TCPWM_OFF_CMP      12'h00C
`define TCPWM_OFF_COUNT    12'h010
`define TCPWM_OFF_CAPT     12'h014
`define TCPWM_OFF_STATUS   12'h018
`define TCPWM_OFF_MASK     12'h01C

// Control register fields
`define TCPWM_CTRL_EN      0
`define TCPWM_CTRL_MODE_LO 1
`define TCPWM_CTRL_MODE_HI 2
`define TCPWM_CTRL_SRC     3
`define TCPWM_CTRL_CAPEN   4
`define TCPWM_CTRL_DOWN    5
`define TCPWM_CTRL_INV     6
`define TCPWM_CTRL_WIDTH   7

// Status bit positions
`define TCPWM_ST_OVF       0
`define TCPWM_ST_CMP       1
`define TCPWM_ST_CAP       2
`define TCPWM_ST_WIDTH     3

// Modes
`define TCPWM_MODE_WDT     2'b00
`define TCPWM_MODE_CTC     2'b01
`define TCPWM_MODE_FPWM    2'b10
`define TCPWM_MODE_PFC     2'b11

// Reset values
`define TCPWM_CTRL_RST     7'h00
`define TCPWM_PRESC_RST    16'h0000
`define TCPWM_TOP_RST      16'hFFFF
`define TCPWM_CMP_RST      16'h8000
`define TCPWM_MASK_RST     3'h0
`define TCPWM_CNT_ZERO     16'h0000
`define TCPWM_CNT_ONE      16'h0001

`endif

// >>> core/tcpwm_sync.v
// Three-stage input synchroniser with agreement of the last two stages
module tcpwm_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output reg  dout,
  output wire rise
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      dout   <= RST_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A change counts only once stages two and three agree
      if (s2_reg == s3_reg) begin
        dout <= s3_reg;
      end
    end
  end

  assign rise = (s2_reg == s3_reg) && s3_reg && !dout;
endmodule // tcpwm_sync

// >>> core/tcpwm_presc.v
// Programmable prescaler that turns a tick source into a count enable
module tcpwm_presc #(
  parameter W = 16
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         run,
  input  wire         tick,
  input  wire [W-1:0] divide,
  output reg          cnt_en
);
  reg [W-1:0] div_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= {W{1'b0}};
      cnt_en  <= 1'b0;
    end else if (!run) begin
      div_reg <= {W{1'b0}};
      cnt_en  <= 1'b0;
    end else begin
      cnt_en <= 1'b0;
      if (tick) begin
        // Divide by divide+1; zero passes every tick
        if (div_reg >= divide) begin
          div_reg <= {W{1'b0}};
          cnt_en  <= 1'b1;
        end else begin
          div_reg <= div_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // tcpwm_presc

// >>> core/tcpwm_top.v
// Timer/counter with compare output, PWM, input capture and APB registers
//
// Behaviour
// - A 16-bit up or down counter with a compare unit driving PWM output.
// - Modes: watchdog, clear on compare match, fast PWM, phase-frequency PWM.
// - Count clock source selectable, then divided by a programmable prescaler.
// - Overflow, compare match and capture each raise an interrupt request.
// - One static interrupt output plus a separate wake-up interrupt output.
// - PWM compare value and top reload only at period end, so no glitches.
// - Synchronised rising capture edge copies the count into the capture register.
// - Capture works only outside PWM modes and only with the bus in use.
// - Without the bus the interrupt output is the overflow flag.
// - With the bus, status, mask and clear-on-read registers govern the interrupt.
// - Host reaches control and status registers as a bus slave.
// - Stand-alone mode runs from preset control values and the reset pin.
// - Reset pin kept enabled by a preset enable, and it resets the counter.
`include "tcpwm_regs.vh"

module tcpwm_top #(
  parameter             CW          = 16,
  parameter             BUS_USED    = 1'b1,
  parameter [6:0]       PRE_CTRL    = 7'h01,
  parameter [15:0]      PRE_PRESC   = 16'h0000,
  parameter [15:0]      PRE_TOP     = 16'hFFFF,
  parameter [15:0]      PRE_CMP     = 16'h8000,
  parameter             PRE_RST_ENA = 1'b1
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output reg  [31:0]   prdata,
  output wire          pslverr,
  input  wire          count_clock_in,
  input  wire          counter_reset_n_pin,
  input  wire          capture_trigger_in,
  output reg           counter_irq_out,
  output reg           wake_irq_out,
  output reg           compare_wave_out,
  output reg  [CW-1:0] count_value
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and wiring
  reg  [6:0]    ctrl_reg;
  reg  [15:0]   presc_reg;
  reg  [CW-1:0] top_reg;
  reg  [CW-1:0] cmp_reg;
  reg  [CW-1:0] top_act_reg;
  reg  [CW-1:0] cmp_act_reg;
  reg  [CW-1:0] capture_holding_reg;
  reg  [2:0]    status_reg;
  reg  [2:0]    mask_reg;
  reg           dir_down_reg;
  reg           reset_pin_enable;
  reg           load_done_reg;

  wire          clk_lvl;
  wire          clk_rise;
  wire          rstpin_lvl;
  wire          cap_lvl;
  wire          cap_rise;
  wire          cnt_en;
  wire          tick;

  wire          enabled  = ctrl_reg[`TCPWM_CTRL_EN];
  wire [1:0]    mode     = ctrl_reg[`TCPWM_CTRL_MODE_HI:`TCPWM_CTRL_MODE_LO];
  wire          is_pwm   = mode[1];

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  tcpwm_sync u_sync_clk (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (count_clock_in),
    .dout    (clk_lvl),
    .rise    (clk_rise)
  );

  // The reset pin idles high, so its chain starts high: no false pin reset after presetn
  tcpwm_sync #(.RST_VAL(1'b1)) u_sync_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (counter_reset_n_pin),
    .dout    (rstpin_lvl),
    .rise    ()
  );

  tcpwm_sync u_sync_cap (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (capture_trigger_in),
    .dout    (cap_lvl),
    .rise    (cap_rise)
  );

  // Either the system clock or the synchronised external clock edge
  assign tick = ctrl_reg[`TCPWM_CTRL_SRC] ? clk_rise : 1'b1;

  // Pin reset only counts while its enable is on
  wire pin_reset = reset_pin_enable && !rstpin_lvl;

  tcpwm_presc #(
    .W (16)
  ) u_presc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enabled && !pin_reset),
    .tick    (tick),
    .divide  (presc_reg),
    .cnt_en  (cnt_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  wire bus_on   = (BUS_USED != 0);
  wire acc      = psel && penable && bus_on;
  wire wr_acc   = acc && pwrite;
  wire rd_acc   = acc && !pwrite;
  wire known    = is_addr(paddr, `TCPWM_OFF_CTRL)   || is_addr(paddr, `TCPWM_OFF_PRESC) ||
                  is_addr(paddr, `TCPWM_OFF_TOP)    || is_addr(paddr, `TCPWM_OFF_CMP)   ||
                  is_addr(paddr, `TCPWM_OFF_COUNT)  || is_addr(paddr, `TCPWM_OFF_CAPT)  ||
                  is_addr(paddr, `TCPWM_OFF_STATUS) || is_addr(paddr, `TCPWM_OFF_MASK);
  wire st_read  = rd_acc && is_addr(paddr, `TCPWM_OFF_STATUS);
  wire cnt_wr   = wr_acc && is_addr(paddr, `TCPWM_OFF_COUNT);

  assign pready  = 1'b1;
  assign pslverr = acc && !known;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (!pwrite && bus_on) begin
        case (paddr)
          `TCPWM_OFF_CTRL:   prdata[6:0]    <= ctrl_reg;
          `TCPWM_OFF_PRESC:  prdata[15:0]   <= presc_reg;
          `TCPWM_OFF_TOP:    prdata[CW-1:0] <= top_reg;
          `TCPWM_OFF_CMP:    prdata[CW-1:0] <= cmp_reg;
          `TCPWM_OFF_COUNT:  prdata[CW-1:0] <= count_value;
          `TCPWM_OFF_CAPT:   prdata[CW-1:0] <= capture_holding_reg;
          `TCPWM_OFF_STATUS: prdata[2:0]    <= status_reg;
          `TCPWM_OFF_MASK:   prdata[2:0]    <= mask_reg;
          default:           prdata         <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers start from preset values so stand-alone use needs no bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg         <= `TCPWM_CTRL_RST;
      presc_reg        <= `TCPWM_PRESC_RST;
      top_reg          <= `TCPWM_TOP_RST;
      cmp_reg          <= `TCPWM_CMP_RST;
      mask_reg         <= `TCPWM_MASK_RST;
      reset_pin_enable <= 1'b0;
      load_done_reg    <= 1'b0;
    end else if (!load_done_reg) begin
      ctrl_reg         <= PRE_CTRL;
      presc_reg        <= PRE_PRESC;
      top_reg          <= PRE_TOP[CW-1:0];
      cmp_reg          <= PRE_CMP[CW-1:0];
      reset_pin_enable <= PRE_RST_ENA;
      load_done_reg    <= 1'b1;
    end else if (wr_acc) begin
      case (paddr)
        `TCPWM_OFF_CTRL:  ctrl_reg  <= pwdata[6:0];
        `TCPWM_OFF_PRESC: presc_reg <= pwdata[15:0];
        `TCPWM_OFF_TOP:   top_reg   <= pwdata[CW-1:0];
        `TCPWM_OFF_CMP:   cmp_reg   <= pwdata[CW-1:0];
        `TCPWM_OFF_MASK:  mask_reg  <= pwdata[2:0];
        default:          ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter core
  wire at_top   = (count_value >= top_act_reg);
  wire at_zero  = (count_value == {CW{1'b0}});
  wire counting_down = (mode == `TCPWM_MODE_PFC) ? dir_down_reg : ctrl_reg[`TCPWM_CTRL_DOWN];
  reg  ovf_ev;
  reg  cmp_ev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value  <= {CW{1'b0}};
      dir_down_reg <= 1'b0;
      top_act_reg  <= {CW{1'b1}};
      cmp_act_reg  <= {1'b1, {(CW-1){1'b0}}};
      ovf_ev       <= 1'b0;
      cmp_ev       <= 1'b0;
    end else begin
      ovf_ev <= 1'b0;
      cmp_ev <= 1'b0;
      if (pin_reset) begin
        count_value  <= {CW{1'b0}};
        dir_down_reg <= 1'b0;
      end else if (cnt_wr) begin
        count_value <= pwdata[CW-1:0];
      end else if (cnt_en) begin
        if (count_value == cmp_act_reg) begin
          cmp_ev <= 1'b1;
        end
        case (mode)
          `TCPWM_MODE_WDT: begin
            // Free run, wrap both ways across the full range
            if (counting_down) begin
              count_value <= count_value - {{(CW-1){1'b0}}, 1'b1};
              if (at_zero) ovf_ev <= 1'b1;
            end else begin
              count_value <= count_value + {{(CW-1){1'b0}}, 1'b1};
              if (&count_value) ovf_ev <= 1'b1;
            end
          end
          `TCPWM_MODE_CTC: begin
            if (count_value >= cmp_act_reg) begin
              count_value <= {CW{1'b0}};
              ovf_ev      <= 1'b1;
            end else begin
              count_value <= count_value + {{(CW-1){1'b0}}, 1'b1};
            end
          end
          `TCPWM_MODE_FPWM: begin
            if (at_top) begin
              count_value <= {CW{1'b0}};
              ovf_ev      <= 1'b1;
              top_act_reg <= top_reg;
              cmp_act_reg <= cmp_reg;
            end else begin
              count_value <= count_value + {{(CW-1){1'b0}}, 1'b1};
            end
          end
          default: begin
            // Phase and frequency correct: up to top, down to zero, reload at zero
            if (counting_down) begin
              if (count_value <= {{(CW-1){1'b0}}, 1'b1}) begin
                count_value  <= {CW{1'b0}};
                dir_down_reg <= 1'b0;
                ovf_ev       <= 1'b1;
                top_act_reg  <= top_reg;
                cmp_act_reg  <= cmp_reg;
              end else begin
                count_value <= count_value - {{(CW-1){1'b0}}, 1'b1};
              end
            end else if (at_top) begin
              count_value  <= count_value - {{(CW-1){1'b0}}, 1'b1};
              dir_down_reg <= 1'b1;
            end else begin
              count_value <= count_value + {{(CW-1){1'b0}}, 1'b1};
            end
          end
        endcase
      end
      // Outside PWM the compare and top registers take effect at once
      if (!is_pwm) begin
        top_act_reg <= top_reg;
        cmp_act_reg <= cmp_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_wave_out <= 1'b0;
    end else if (is_pwm) begin
      // Registered comparison against shadowed values keeps the edge clean
      compare_wave_out <= (count_value < cmp_act_reg) ^ ctrl_reg[`TCPWM_CTRL_INV];
    end else if (cmp_ev) begin
      compare_wave_out <= ~compare_wave_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture
  wire cap_ev = cap_rise && ctrl_reg[`TCPWM_CTRL_CAPEN] && !is_pwm && bus_on;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_holding_reg <= {CW{1'b0}};
    end else if (cap_ev) begin
      capture_holding_reg <= count_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  wire [2:0] ev_vec = {cap_ev, cmp_ev, ovf_ev};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 3'b000;
    end else begin
      // A new event wins over the clear from a status read
      status_reg <= (st_read ? 3'b000 : status_reg) | ev_vec;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_irq_out <= 1'b0;
      wake_irq_out    <= 1'b0;
    end else begin
      if (bus_on) begin
        counter_irq_out <= |(status_reg & mask_reg);
      end else begin
        counter_irq_out <= status_reg[`TCPWM_ST_OVF];
      end
      wake_irq_out <= |status_reg;
    end
  end

endmodule // tcpwm_top

// >>> verif/tcpwm_top_properties.sv
// Port-level concurrent checks for the timer/counter
`include "tcpwm_regs.vh"
module tcpwm_properties #(
  parameter CW = 16
) (
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire [11:0]   paddr,
  input wire [31:0]   pwdata,
  input wire          pready,
  input wire [31:0]   prdata,
  input wire          pslverr,
  input wire          counter_reset_n_pin,
  input wire          counter_irq_out,
  input wire          wake_irq_out,
  input wire          compare_wave_out,
  input wire [CW-1:0] count_value
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Write data of the previous cycle, for the count load check
  reg [CW-1:0] wd_q;
  always @(posedge pclk) begin
    wd_q <= pwdata[CW-1:0];
  end
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  a_err_unmapped: assert property (psel && penable && paddr >= 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  a_read_unmapped_zero: assert property (
    psel && penable && !pwrite && paddr >= 12'h020 |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_pin_clears_count: assert property (!counter_reset_n_pin [*8] |-> count_value == 0)
    else $error("reset pin did not clear count");
  a_irq_needs_wake: assert property (counter_irq_out |-> wake_irq_out)
    else $error("interrupt without wake");
  a_count_write_load: assert property (
    psel && penable && pwrite && paddr == `TCPWM_OFF_COUNT && counter_reset_n_pin
    |=> count_value == wd_q || count_value == wd_q + 1'b1 || count_value == wd_q - 1'b1)
    else $error("count write not loaded");
  a_reset_quiet: assert property (
    $rose(presetn) |-> count_value == 0 && !counter_irq_out && !compare_wave_out)
    else $error("outputs not cleared by reset");
endmodule // tcpwm_properties

// >>> verif/tcpwm_pin_model.sv
// Far-side pin driver: count clock bursts and capture pulses
module tcpwm_pin_model (
  input  wire  pclk,
  output logic count_clock_in,
  output logic capture_trigger_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    count_clock_in = 1'b0;
    capture_trigger_in = 1'b0;
  end
  // Slow enough for the synchroniser; clock stands low between bursts
  task automatic clock_burst(input int cnt);
    repeat (cnt) begin
      repeat (4) @(posedge pclk);
      count_clock_in <= 1'b1;
      repeat (4) @(posedge pclk);
      count_clock_in <= 1'b0;
    end
  endtask
  task automatic capture_pulse();
    @(posedge pclk);
    capture_trigger_in <= 1'b1;
    repeat (6) @(posedge pclk);
    capture_trigger_in <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
endmodule // tcpwm_pin_model

// >>> verif/timer_counter_pwm_capture_tb.sv
// Self-checking bench for the timer/counter over APB and its pins
`include "tcpwm_regs.vh"
module timer_counter_pwm_capture_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire         pready;
  wire  [31:0] prdata;
  wire         pslverr;
  wire         count_clock_in;
  logic        counter_reset_n_pin;
  wire         capture_trigger_in;
  wire         counter_irq_out;
  wire         wake_irq_out;
  wire         compare_wave_out;
  wire  [15:0] count_value;
  wire         solo_irq;
  wire  [15:0] solo_cnt;
  int          err_total;
  int          check_count;
  int          n;
  logic [31:0] v;
  logic [31:0] v0;
  logic        e;
  tcpwm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .count_clock_in(count_clock_in),
    .counter_reset_n_pin(counter_reset_n_pin), .capture_trigger_in(capture_trigger_in),
    .counter_irq_out(counter_irq_out), .wake_irq_out(wake_irq_out),
    .compare_wave_out(compare_wave_out), .count_value(count_value));
  tcpwm_pin_model pins_u (.pclk(pclk), .count_clock_in(count_clock_in),
    .capture_trigger_in(capture_trigger_in));
  // Stand-alone copy: no bus, runs from preset controls and the reset pin only
  tcpwm_top #(.BUS_USED(1'b0), .PRE_CTRL(7'h03), .PRE_CMP(16'h0010)) solo_u (
    .pclk(pclk), .presetn(presetn), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
    .paddr(12'h000), .pwdata(32'h0000_0000), .pready(), .prdata(), .pslverr(),
    .count_clock_in(count_clock_in), .counter_reset_n_pin(counter_reset_n_pin),
    .capture_trigger_in(capture_trigger_in), .counter_irq_out(solo_irq),
    .wake_irq_out(), .compare_wave_out(), .count_value(solo_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ends one edge after release so the next call never lands on the same edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      err_total++;
      final_report();
    end
    v = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(v, exp);
  endtask
  task automatic wait_hi(input bit irq);
    n = 0;
    while ((irq ? counter_irq_out : wake_irq_out) !== 1'b1 && n < 80) begin
      @(posedge pclk);
      n++;
    end
    if (n == 80) begin
      err_total++;
      final_report();
    end
  endtask
  // Whole periods of 10 or 20 cycles fit the 100-cycle window exactly
  task automatic duty(input logic [31:0] exp);
    logic [31:0] hi;
    hi = 32'h0000_0000;
    repeat (20) @(posedge pclk);
    repeat (100) begin
      @(posedge pclk);
      hi = hi + compare_wave_out;
    end
    check(hi, exp);
  endtask
  task automatic restart(input logic [31:0] ctrl, input logic [31:0] cnt);
    apb(1'b1, `TCPWM_OFF_CTRL, 32'h0000_0000);
    apb(1'b1, `TCPWM_OFF_COUNT, cnt);
    apb(1'b0, `TCPWM_OFF_STATUS, 32'h0000_0000);
    apb(1'b1, `TCPWM_OFF_CTRL, ctrl);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    counter_reset_n_pin = 1'b1;
    err_total = 0;
    check_count = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check(solo_irq, 1'b0);
    rdc(`TCPWM_OFF_CTRL, 32'h0000_0001);
    rdc(`TCPWM_OFF_PRESC, 32'h0000_0000);
    rdc(`TCPWM_OFF_TOP, 32'h0000_FFFF);
    rdc(`TCPWM_OFF_CMP, 32'h0000_8000);
    rdc(`TCPWM_OFF_MASK, 32'h0000_0000);
    rdc(12'h020, 32'h0000_0000);
    check(e, 1'b1);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `TCPWM_OFF_CTRL, m * 2);
      rdc(`TCPWM_OFF_CTRL, m * 2);
    end
    apb(1'b1, `TCPWM_OFF_CAPT, 32'h0000_AAAA);
    rdc(`TCPWM_OFF_CAPT, 32'h0000_0000);
    apb(1'b1, `TCPWM_OFF_MASK, 32'h0000_0001);
    restart(32'h0000_0001, 32'h0000_FFF0);
    wait_hi(1'b1);
    check(wake_irq_out, 1'b1);
    rdc(`TCPWM_OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check(counter_irq_out, 1'b0);
    apb(1'b1, `TCPWM_OFF_MASK, 32'h0000_0000);
    apb(1'b1, `TCPWM_OFF_COUNT, 32'h0000_FFF0);
    wait_hi(1'b0);
    check(counter_irq_out, 1'b0);
    rdc(`TCPWM_OFF_STATUS, 32'h0000_0001);
    restart(32'h0000_0021, 32'h0000_0100);
    apb(1'b0, `TCPWM_OFF_COUNT, 32'h0000_0000);
    v0 = v;
    apb(1'b0, `TCPWM_OFF_COUNT, 32'h0000_0000);
    check(v < v0, 1'b1);
    apb(1'b1, `TCPWM_OFF_CMP, 32'h0000_0009);
    restart(32'h0000_0003, 32'h0000_0000);
    duty(32'h0000_0032);
    rdc(`TCPWM_OFF_STATUS, 32'h0000_0003);
    apb(1'b1, `TCPWM_OFF_TOP, 32'h0000_0009);
    apb(1'b1, `TCPWM_OFF_CMP, 32'h0000_0004);
    restart(32'h0000_0005, 32'h0000_0000);
    duty(32'h0000_0028);
    apb(1'b1, `TCPWM_OFF_CTRL, 32'h0000_0045);
    duty(32'h0000_003C);
    // Up/down period of twice top: 0..10 then 9..1, seven counts below compare
    apb(1'b1, `TCPWM_OFF_TOP, 32'h0000_000A);
    restart(32'h0000_0007, 32'h0000_0000);
    duty(32'h0000_0023);
    restart(32'h0000_0015, 32'h0000_0000);
    pins_u.capture_pulse();
    apb(1'b0, `TCPWM_OFF_STATUS, 32'h0000_0000);
    check(v[2], 1'b0);
    apb(1'b1, `TCPWM_OFF_TOP, 32'h0000_FFFF);
    apb(1'b1, `TCPWM_OFF_CMP, 32'h0000_FFFF);
    restart(32'h0000_0013, 32'h0000_0000);
    apb(1'b0, `TCPWM_OFF_COUNT, 32'h0000_0000);
    v0 = v;
    pins_u.capture_pulse();
    apb(1'b0, `TCPWM_OFF_CAPT, 32'h0000_0000);
    check(v > v0 && v < v0 + 40, 1'b1);
    apb(1'b0, `TCPWM_OFF_STATUS, 32'h0000_0000);
    check(v[2], 1'b1);
    restart(32'h0000_0009, 32'h0000_0000);
    pins_u.clock_burst(10);
    repeat (8) @(posedge pclk);
    rdc(`TCPWM_OFF_COUNT, 32'h0000_000A);
    apb(1'b1, `TCPWM_OFF_PRESC, 32'h0000_0001);
    restart(32'h0000_0009, 32'h0000_0000);
    pins_u.clock_burst(10);
    repeat (8) @(posedge pclk);
    apb(1'b0, `TCPWM_OFF_COUNT, 32'h0000_0000);
    check(v == 5 || v == 4, 1'b1);
    apb(1'b1, `TCPWM_OFF_CTRL, 32'h0000_0001);
    counter_reset_n_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    rdc(`TCPWM_OFF_COUNT, 32'h0000_0000);
    check(count_value, 32'h0000_0000);
    check(solo_cnt, 32'h0000_0000);
    check(solo_irq, 1'b1);
    counter_reset_n_pin <= 1'b1;
    final_report();
  end
endmodule // timer_counter_pwm_capture_tb
bind tcpwm_top tcpwm_properties #(.CW(CW)) chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .counter_reset_n_pin(counter_reset_n_pin), .counter_irq_out(counter_irq_out),
  .wake_irq_out(wake_irq_out), .compare_wave_out(compare_wave_out),
  .count_value(count_value));
